// [hdl/tpo_regs.sv]
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tpo_params.svh"

module tpo_regs #(
  parameter int CHANNELS = `TPO_CHANNELS
) (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  clkEn,
  // power modes
  input  wire logic                  hwStandby,
  input  wire logic                  swStandby,
  // register bus
  input  wire tpo_pkg::tpo_bus_s     bus,
  output logic      [`TPO_DATA_W-1:0] rdData,
  // timer compare match pulses
  input  wire logic [CHANNELS-1:0]   compareMatch,
  // pin directions from the port logic
  input  wire logic [7:0]            portADir,
  input  wire logic [3:0]            portBDir,
  // port latches and pattern pins
  output logic      [7:0]            portALatch,
  output logic      [7:0]            portBLatch,
  output tpo_pkg::tpo_pins_s         pins
);

  // ============================================================
  // registers
  logic [7:0]         upperNextPattern;
  logic [7:0]         lowerNextPattern;
  logic [7:0]         portAPatternEnable;
  logic [7:0]         portBPatternEnable;
  tpo_pkg::tpo_trig_s patternTriggerSelect;
  logic [3:0]         portBHigh;
  logic [3:0]         portBLow;

  // ============================================================
  // decode
  logic sharedTrigger;
  logic wrUpper;
  logic wrUpperAlt;
  logic wrLower;
  logic wrEnA;
  logic wrEnB;
  logic wrTrig;
  logic wrLatchA;
  logic wrLatchB;

  // group 3 field has no pins; compared only to steer the mapping
  assign sharedTrigger = (patternTriggerSelect.grp3 ==
                          patternTriggerSelect.grp2);

  assign wrUpper    = bus.wrStrobe && (bus.addr == `TPO_OFS_UPPER_NEXT);
  assign wrUpperAlt = bus.wrStrobe && (bus.addr == `TPO_OFS_UPPER_NEXT_ALT);
  assign wrLower    = bus.wrStrobe && (bus.addr == `TPO_OFS_LOWER_NEXT);
  assign wrEnA      = bus.wrStrobe && (bus.addr == `TPO_OFS_PORT_A_ENABLE);
  assign wrEnB      = bus.wrStrobe && (bus.addr == `TPO_OFS_PORT_B_ENABLE);
  assign wrTrig     = bus.wrStrobe && (bus.addr == `TPO_OFS_TRIGGER_SELECT);
  assign wrLatchA   = bus.wrStrobe && (bus.addr == `TPO_OFS_PORT_A_LATCH);
  assign wrLatchB   = bus.wrStrobe && (bus.addr == `TPO_OFS_PORT_B_LATCH);

  // ============================================================
  // upper next pattern
  // software standby holds everything simply by never touching state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      upperNextPattern <= `TPO_RST_UPPER_NEXT;
    end else if (clkEn) begin
      if (hwStandby) begin
        upperNextPattern <= `TPO_RST_UPPER_NEXT;
      end else if (sharedTrigger) begin
        if (wrUpper) begin
          upperNextPattern <= bus.wrData;
        end
      end else begin
        if (wrUpper) begin
          upperNextPattern[7:4] <= bus.wrData[7:4];
        end
        if (wrUpperAlt) begin
          upperNextPattern[3:0] <= bus.wrData[3:0];
        end
      end
    end
  end

  // ============================================================
  // lower next pattern (group 0 and 1 source)
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      lowerNextPattern <= `TPO_RST_LOWER_NEXT;
    end else if (clkEn) begin
      if (hwStandby) begin
        lowerNextPattern <= `TPO_RST_LOWER_NEXT;
      end else if (wrLower) begin
        lowerNextPattern <= bus.wrData;
      end
    end
  end

  // ============================================================
  // port A enables
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      portAPatternEnable <= `TPO_RST_PORT_A_ENABLE;
    end else if (clkEn) begin
      if (hwStandby) begin
        portAPatternEnable <= `TPO_RST_PORT_A_ENABLE;
      end else if (wrEnA) begin
        portAPatternEnable <= bus.wrData;
      end
    end
  end

  // ============================================================
  // port B enables; top nibble is storage only
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      portBPatternEnable <= `TPO_RST_PORT_B_ENABLE;
    end else if (clkEn) begin
      if (hwStandby) begin
        portBPatternEnable <= `TPO_RST_PORT_B_ENABLE;
      end else if (wrEnB) begin
        portBPatternEnable <= bus.wrData;
      end
    end
  end

  // ============================================================
  // trigger select
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      patternTriggerSelect <= `TPO_RST_TRIGGER_SELECT;
    end else if (clkEn) begin
      if (hwStandby) begin
        patternTriggerSelect <= `TPO_RST_TRIGGER_SELECT;
      end else if (wrTrig) begin
        patternTriggerSelect <= bus.wrData;
      end
    end
  end

  // ============================================================
  // port B high nibble: plain port data, never patterned
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      portBHigh <= `TPO_RST_GROUP_LATCH;
    end else if (clkEn) begin
      if (hwStandby) begin
        portBHigh <= `TPO_RST_GROUP_LATCH;
      end else if (wrLatchB) begin
        portBHigh <= bus.wrData[7:4];
      end
    end
  end

  // ============================================================
  // group transfer slices
  tpo_group_xfer #(
    .W        (`TPO_GROUP_W),
    .CHANNELS (CHANNELS)
  ) u_grp0 (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .clkEn        (clkEn),
    .hwStandby    (hwStandby),
    .trigSel      (patternTriggerSelect.grp0),
    .compareMatch (compareMatch),
    .nextData     (lowerNextPattern[3:0]),
    .enable       (portAPatternEnable[3:0]),
    .swWrite      (wrLatchA),
    .swData       (bus.wrData[3:0]),
    .latch        (portALatch[3:0])
  );

  tpo_group_xfer #(
    .W        (`TPO_GROUP_W),
    .CHANNELS (CHANNELS)
  ) u_grp1 (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .clkEn        (clkEn),
    .hwStandby    (hwStandby),
    .trigSel      (patternTriggerSelect.grp1),
    .compareMatch (compareMatch),
    .nextData     (lowerNextPattern[7:4]),
    .enable       (portAPatternEnable[7:4]),
    .swWrite      (wrLatchA),
    .swData       (bus.wrData[7:4]),
    .latch        (portALatch[7:4])
  );

  tpo_group_xfer #(
    .W        (`TPO_GROUP_W),
    .CHANNELS (CHANNELS)
  ) u_grp2 (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .clkEn        (clkEn),
    .hwStandby    (hwStandby),
    .trigSel      (patternTriggerSelect.grp2),
    .compareMatch (compareMatch),
    .nextData     (upperNextPattern[3:0]),
    .enable       (portBPatternEnable[3:0]),
    .swWrite      (wrLatchB),
    .swData       (bus.wrData[3:0]),
    .latch        (portBLow)
  );

  assign portBLatch = {portBHigh, portBLow};

  // ============================================================
  // pattern pins: direction decides driving, latch keeps updating
  assign pins.value   = {portBLow, portALatch};
  assign pins.drive_n = ~{portBDir, portADir};

  // ============================================================
  // read path, data valid in the cycle after the strobe
  logic [7:0] next_rdData;

  always_comb begin
    next_rdData = `TPO_READ_UNMAPPED;
    unique case (bus.addr)
      `TPO_OFS_UPPER_NEXT: begin
        if (sharedTrigger) begin
          next_rdData = upperNextPattern;
        end else begin
          next_rdData = {upperNextPattern[7:4], `TPO_NIBBLE_ONES};
        end
      end
      `TPO_OFS_UPPER_NEXT_ALT: begin
        if (sharedTrigger) begin
          next_rdData = `TPO_READ_ONES;
        end else begin
          next_rdData = {`TPO_NIBBLE_ONES, upperNextPattern[3:0]};
        end
      end
      `TPO_OFS_LOWER_NEXT:     next_rdData = lowerNextPattern;
      `TPO_OFS_PORT_A_ENABLE:  next_rdData = portAPatternEnable;
      `TPO_OFS_PORT_B_ENABLE:  next_rdData = portBPatternEnable;
      `TPO_OFS_TRIGGER_SELECT: next_rdData = patternTriggerSelect;
      `TPO_OFS_PORT_A_LATCH:   next_rdData = portALatch;
      `TPO_OFS_PORT_B_LATCH:   next_rdData = portBLatch;
      default:                 next_rdData = `TPO_READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdData <= `TPO_READ_UNMAPPED;
    end else if (clkEn) begin
      if (bus.rdStrobe) begin
        rdData <= next_rdData;
      end
    end
  end

  // swStandby needs no action: state holds because nothing clears it
  logic unusedSwStandby;
  assign unusedSwStandby = swStandby;

endmodule : tpo_regs

`default_nettype wire

// [pkg/tpo_params.svh]
`ifndef TPO_PARAMS_SVH
`define TPO_PARAMS_SVH

// ============================================================
// register offsets
`define TPO_OFS_UPPER_NEXT      16'hffa4
`define TPO_OFS_UPPER_NEXT_ALT  16'hffa6
`define TPO_OFS_PORT_A_ENABLE   16'hffa0
`define TPO_OFS_PORT_B_ENABLE   16'hffa1
`define TPO_OFS_TRIGGER_SELECT  16'hffa2
`define TPO_OFS_LOWER_NEXT      16'hffa3
`define TPO_OFS_PORT_A_LATCH    16'hffa8
`define TPO_OFS_PORT_B_LATCH    16'hffa9

// ============================================================
// reset values
`define TPO_RST_UPPER_NEXT      8'h00
`define TPO_RST_PORT_A_ENABLE   8'h00
`define TPO_RST_PORT_B_ENABLE   8'h00
`define TPO_RST_TRIGGER_SELECT  8'hff
`define TPO_RST_LOWER_NEXT      8'h00
`define TPO_RST_LATCH           8'h00
`define TPO_RST_GROUP_LATCH     4'h0
`define TPO_READ_ONES           8'hff
`define TPO_NIBBLE_ONES         4'hf
`define TPO_READ_UNMAPPED       8'h00

// ============================================================
// field positions in the trigger select register
`define TPO_GRP3_MSB            7
`define TPO_GRP3_LSB            6
`define TPO_GRP2_MSB            5
`define TPO_GRP2_LSB            4
`define TPO_GRP1_MSB            3
`define TPO_GRP1_LSB            2
`define TPO_GRP0_MSB            1
`define TPO_GRP0_LSB            0

// ============================================================
// widths
`define TPO_ADDR_W              16
`define TPO_DATA_W              8
`define TPO_GROUP_W             4
`define TPO_CHANNELS            4

`endif

// [pkg/tpo_pkg.sv]
`include "tpo_params.svh"

package tpo_pkg;

  // ============================================================
  // register bus request
  typedef struct packed {
    logic [`TPO_ADDR_W-1:0] addr;
    logic [`TPO_DATA_W-1:0] wrData;
    logic                   wrStrobe;
    logic                   rdStrobe;
  } tpo_bus_s;

  // ============================================================
  // trigger select register layout
  typedef struct packed {
    logic [1:0] grp3;
    logic [1:0] grp2;
    logic [1:0] grp1;
    logic [1:0] grp0;
  } tpo_trig_s;

  // pattern pin group: value and active-low output enables
  typedef struct packed {
    logic [11:0] value;
    logic [11:0] drive_n;
  } tpo_pins_s;

endpackage : tpo_pkg

// [hdl/tpo_group_xfer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpo_params.svh"

module tpo_group_xfer #(
  parameter int W        = `TPO_GROUP_W,
  parameter int CHANNELS = `TPO_CHANNELS
) (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  input  wire logic                hwStandby,
  // trigger
  input  wire logic [1:0]          trigSel,
  input  wire logic [CHANNELS-1:0] compareMatch,
  // pattern data
  input  wire logic [W-1:0]        nextData,
  input  wire logic [W-1:0]        enable,
  // software write
  input  wire logic                swWrite,
  input  wire logic [W-1:0]        swData,
  // latch
  output logic      [W-1:0]        latch
);

  logic fire;

  assign fire = compareMatch[trigSel];

  // ============================================================
  // per-bit latch update
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
          latch[i] <= 1'b0;
        end else if (clkEn) begin
          if (hwStandby) begin
            latch[i] <= 1'b0;
          end else if (enable[i]) begin
            // enabled bits ignore software; only the trigger moves them
            if (fire) begin
              latch[i] <= nextData[i];
            end
          end else if (swWrite) begin
            latch[i] <= swData[i];
          end
        end
      end
    end
  endgenerate

endmodule : tpo_group_xfer

`default_nettype wire

// [verif/tpo_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
`include "tpo_params.svh"
module tpo_regs_chk #(
  parameter int CHANNELS = `TPO_CHANNELS
) (
  // clock, reset, modes
  input wire logic                    mclk,
  input wire logic                    reset_n,
  input wire logic                    clkEn,
  input wire logic                    hwStandby,
  input wire logic                    swStandby,
  // register bus
  input wire tpo_pkg::tpo_bus_s       bus,
  input wire logic [`TPO_DATA_W-1:0]  rdData,
  // timer and pins
  input wire logic [CHANNELS-1:0]     compareMatch,
  input wire logic [7:0]              portADir,
  input wire logic [3:0]              portBDir,
  input wire logic [7:0]              portALatch,
  input wire logic [7:0]              portBLatch,
  input wire tpo_pkg::tpo_pins_s      pins
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // ========
  // pins
  pin_value_a: assert property (pins.value == {portBLatch[3:0], portALatch})
    else $error("pattern pins differ from latches");
  drive_map_a: assert property (pins.drive_n == ~{portBDir, portADir})
    else $error("pin drive does not follow direction");
  // ========
  // latches move only on a trigger, a write or hardware standby
  latch_a_hold_a: assert property (clkEn && !hwStandby && compareMatch == '0
    && !(bus.wrStrobe && bus.addr == 16'hffa8) |=> $stable(portALatch))
    else $error("port A latch moved without cause");
  latch_b_hold_a: assert property (clkEn && !hwStandby && compareMatch == '0
    && !(bus.wrStrobe && bus.addr == 16'hffa9) |=> $stable(portBLatch))
    else $error("port B latch moved without cause");
  freeze_a: assert property (!clkEn |=> $stable(rdData) && $stable(portBLatch))
    else $error("state moved with clock enable low");
  // ========
  // hardware standby values and port B enable readback, read two cycles on
  standby_sel_a: assert property (hwStandby && clkEn ##1 !hwStandby && !bus.wrStrobe
    ##1 bus.rdStrobe && bus.addr == 16'hffa2 |=> rdData == 8'hff)
    else $error("trigger select not all ones after standby");
  standby_ena_a: assert property (hwStandby && clkEn ##1 !hwStandby && !bus.wrStrobe
    ##1 bus.rdStrobe && bus.addr == 16'hffa0 |=> rdData == 8'h00)
    else $error("port A enable not cleared by standby");
  standby_next_a: assert property (hwStandby && clkEn ##1 !hwStandby && !bus.wrStrobe
    ##1 bus.rdStrobe && bus.addr == 16'hffa4 |=> rdData == 8'h00)
    else $error("upper next not cleared by standby");
  enb_echo_a: assert property (bus.wrStrobe && clkEn && !hwStandby && bus.addr == 16'hffa1
    ##1 !bus.wrStrobe && !hwStandby ##1 bus.rdStrobe && !hwStandby && bus.addr == 16'hffa1
    |=> rdData == $past(bus.wrData, 3))
    else $error("port B enable does not read back");
endmodule : tpo_regs_chk

bind tpo_regs tpo_regs_chk #(.CHANNELS(CHANNELS)) i_tpo_regs_chk (.mclk(mclk),
  .reset_n(reset_n), .clkEn(clkEn), .hwStandby(hwStandby), .swStandby(swStandby),
  .bus(bus), .rdData(rdData), .compareMatch(compareMatch), .portADir(portADir),
  .portBDir(portBDir), .portALatch(portALatch), .portBLatch(portBLatch), .pins(pins));
`default_nettype wire

// [verif/tpo_timer_model.sv]
`timescale 1ns/1ps
`default_nettype none
module tpo_timer_model (
  // clock and reset
  input wire logic  mclk,
  input wire logic  reset_n,
  // request: pulse channel chan delay+1 cycles after start
  input wire logic        start,
  input wire logic [1:0]  chan,
  input wire logic [3:0]  delay,
  // compare match pulses
  output logic     [3:0]  compareMatch
);
  logic [4:0] count;
  logic [1:0] ch;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count <= 5'h00;
      ch <= 2'h0;
      compareMatch <= 4'h0;
    end else begin
      compareMatch <= 4'h0;
      if (start) begin
        count <= {1'b0, delay} + 5'h01;
        ch <= chan;
      end else if (count == 5'h01) begin
        compareMatch[ch] <= 1'b1;
        count <= 5'h00;
      end else if (count != 5'h00) begin
        count <= count - 5'h01;
      end
    end
  end
endmodule : tpo_timer_model
`default_nettype wire

// [verif/tb_tpo_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_tpo_regs;
  logic               mclk, reset_n, clkEn, hwStandby, swStandby, start;
  tpo_pkg::tpo_bus_s  bus;
  tpo_pkg::tpo_pins_s pins;
  logic [7:0]         rdData, portALatch, portBLatch, portADir;
  logic [3:0]         portBDir, compareMatch, delay, lo;
  logic [1:0]         chan;
  int                 failures = 0;
  int                 checks = 0;
  int                 cycles = 0;

  tpo_regs i_tpo_regs (.mclk(mclk), .reset_n(reset_n), .clkEn(clkEn), .hwStandby(hwStandby),
    .swStandby(swStandby), .bus(bus), .rdData(rdData), .compareMatch(compareMatch),
    .portADir(portADir), .portBDir(portBDir), .portALatch(portALatch),
    .portBLatch(portBLatch), .pins(pins));
  tpo_timer_model i_tpo_timer_model (.mclk(mclk), .reset_n(reset_n), .start(start),
    .chan(chan), .delay(delay), .compareMatch(compareMatch));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // hang guard, far above the roughly 170 cycles the run needs
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      $display("unexpected at %0t: run did not finish in time", $time);
      stop_test();
    end
  end

  // ========
  // access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk) bus.wrStrobe <= 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk) bus.rdStrobe <= 1'b0;
    #1 chk(rdData, e);
  endtask : rd
  task automatic sb(input logic [15:0] a, input logic [7:0] e);
    @(posedge mclk) hwStandby <= 1'b1;
    @(posedge mclk) hwStandby <= 1'b0;
    rd(a, e);
  endtask : sb
  // timer pulse, then let the latch edge land
  task automatic fire(input logic [1:0] c, input logic [3:0] d);
    @(posedge mclk);
    start <= 1'b1;
    chan <= c;
    delay <= d;
    @(posedge mclk) start <= 1'b0;
    repeat (20) begin
      @(posedge mclk) #1;
      if (compareMatch !== 4'h0) break;
    end
    @(posedge mclk) #1;
  endtask : fire
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  // ========
  // tests
  initial begin
    reset_n = 1'b0;
    clkEn = 1'b1;
    hwStandby = 1'b0;
    swStandby = 1'b0;
    start = 1'b0;
    chan = 2'h0;
    delay = 4'h0;
    bus = '0;
    portADir = 8'h3c;
    portBDir = 4'h5;
    lo = 4'h0;
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    rd(16'hffa4, 8'h00);
    rd(16'hffa0, 8'h00);
    rd(16'hffa1, 8'h00);
    rd(16'hffa2, 8'hff);
    rd(16'hffa6, 8'hff);
    rd(16'hffb0, 8'h00);
    chk(pins.drive_n[11:4], 8'hac);
    $display("reset values test done");
    wr(16'hffa4, 8'hca);
    rd(16'hffa4, 8'hca);
    wr(16'hffa6, 8'h00);
    rd(16'hffa6, 8'hff);
    wr(16'hffa9, 8'h3f);
    wr(16'hffa1, 8'hf5);
    rd(16'hffa1, 8'hf5);
    fire(2'h2, 4'h0);
    chk(portBLatch, 8'h3f);
    fire(2'h3, 4'h7);
    chk(portBLatch, 8'h3a);
    wr(16'hffa9, 8'hff);
    rd(16'hffa9, 8'hfa);
    $display("shared trigger test done");
    wr(16'hffa2, 8'h60);
    rd(16'hffa4, 8'hcf);
    rd(16'hffa6, 8'hfa);
    wr(16'hffa6, 8'h09);
    wr(16'hffa4, 8'h10);
    rd(16'hffa4, 8'h1f);
    rd(16'hffa6, 8'hf9);
    wr(16'hffa0, 8'hff);
    wr(16'hffa3, 8'h77);
    fire(2'h2, 4'h3);
    chk(portBLatch, 8'hfb);
    chk(portALatch, 8'h00);
    wr(16'hffa6, 8'h00);
    fire(2'h1, 4'h0);
    chk(portBLatch, 8'hfb);
    $display("split trigger test done");
    for (int c = 0; c < 4; c++) begin
      wr(16'hffa2, {4'hf, c[1:0], c[1:0] ^ 2'h1});
      wr(16'hffa3, 8'(8'h11 * (c + 1)));
      fire(c[1:0], 4'(c));
      chk(portALatch, {4'(c + 1), lo});
      fire(c[1:0] ^ 2'h1, 4'h0);
      lo = 4'(c + 1);
      chk(portALatch, {lo, lo});
    end
    $display("group select test done");
    @(posedge mclk) swStandby <= 1'b1;
    rd(16'hffa1, 8'hf5);
    rd(16'hffa0, 8'hff);
    rd(16'hffa4, 8'h10);
    sb(16'hffa4, 8'h00);
    sb(16'hffa0, 8'h00);
    sb(16'hffa1, 8'h00);
    sb(16'hffa2, 8'hff);
    // a write while the clock enable is low must be lost
    @(posedge mclk) clkEn <= 1'b0;
    wr(16'hffa0, 8'h55);
    @(posedge mclk) clkEn <= 1'b1;
    rd(16'hffa0, 8'h00);
    $display("standby test done");
    stop_test();
  end
endmodule : tb_tpo_regs
`default_nettype wire
